// ### verilog/blr_top.sv
// Notes on behaviour
// - Stop the measurement when the checked-block count reaches its limit.
// - Stop the measurement when the failing-block count reaches its limit.
// - Both limits watched together; the stopping cause is reported.
// - Checksum type output is fixed to the one 16-bit CRC kind.
// - Data sense setting may complement every incoming bit before checking.
// - Slope setting picks rising or falling bit-clock edge for sampling.
// - Enable polarity setting decides which enable level marks information bits.
// - Checksum uses generator x^16 + x^12 + x^5 + 1 only.
// - Checksum register cleared to zero at each information start edge.
// - Each information bit is shifted through the checksum, one per edge.
// - Received checksum captured separately and compared whole with computed one.
// - Block and failing-block counters are both 32 bits wide.
// - After a stop, no new run until the controller acknowledges reading results or selects mode off.
// - Separate activity flags for clock, data and checksum synchronisation.
// - Mode off stops, auto restarts after each stop, single runs once.
// - Results valid only while clock, data and sync flags all stand.
// - Single mode run starts on a trigger and runs to a limit.
`timescale 1ns/10ps
`include "blr_map.svh"

module blr_top
#(
    parameter int unsigned ACT_TIMEOUT_CYC = `BLR_ACT_TIMEOUT_CYC
)
(
    // System clock, reset and freeze
    input  wire logic                    clk,
    input  wire logic                    nrst,
    input  wire logic                    ce,
    // Link pins from the device under test
    input  wire logic                    bit_clk,
    input  wire logic                    data_in,
    input  wire logic                    enable_in,
    // Configuration
    input  wire blr_pkg::blr_cfg_t       cfg,
    input  wire blr_pkg::blr_mode_t      mode,
    input  wire logic [31:0]             block_count_limit,
    input  wire logic [31:0]             max_error_limit,
    // Controller strobes
    input  wire logic                    single_trigger,
    input  wire logic                    result_read,
    // Results
    output logic [31:0]                  total_blocks,
    output logic [31:0]                  failed_blocks,
    output blr_pkg::blr_status_t         status,
    output blr_pkg::blr_crc_type_t       checksum_type
);
    import blr_pkg::*;

    // ****************************************************************
    // Elaboration checks
    // ****************************************************************
    localparam int unsigned IDLE_MAX = (1 << `BLR_IDLE_W) - 1;
    localparam logic [15:0] IDLE_LIM = ACT_TIMEOUT_CYC[15:0];

    // Refuse a window that the 16-bit idle counters cannot reach
    if (ACT_TIMEOUT_CYC < 1 || ACT_TIMEOUT_CYC >= IDLE_MAX)
    begin
        $error("activity timeout does not fit its counter");
    end

    // ****************************************************************
    // Link domain
    // ****************************************************************
    logic blk_tog;
    logic blk_fail;
    logic act_tog;

    // Block framing and checksum run on the bit clock itself
    blr_link blr_link_i
    (
        .bit_clk   (bit_clk),
        .nrst      (nrst),
        .data_in   (data_in),
        .enable_in (enable_in),
        .cfg       (cfg),
        .blk_tog   (blk_tog),
        .blk_fail  (blk_fail),
        .act_tog   (act_tog)
    );

    // ****************************************************************
    // System domain state
    // ****************************************************************
    blr_top_st_t q;
    blr_top_st_t d;

    logic        blk_evt;
    logic        blk_bad;
    logic        clk_edge;
    logic        dat_edge;
    logic        clk_act;
    logic        dat_act;
    logic [31:0] total_nx;
    logic [31:0] errs_nx;
    logic        hit_blocks;
    logic        hit_errors;

    // Event from the link: toggle seen one stage past the synchroniser
    assign blk_evt = q.tog_s[2] ^ q.tog_s[3];

    // Fail flag was stable long before the toggle cleared its stages
    assign blk_bad = q.fail_s[1];

    // Edges taken only from second and later stages
    assign clk_edge = q.clk_s[1] ^ q.clk_s[2];
    assign dat_edge = q.dat_s[1] ^ q.dat_s[2];

    // Activity while the idle counters are under the window
    assign clk_act = (q.clk_idle < IDLE_LIM);
    assign dat_act = (q.dat_idle < IDLE_LIM);

    // Counts after taking the current block
    assign total_nx = q.total + `BLR_CNT_ONE;
    assign errs_nx  = blk_bad ? (q.errs + `BLR_CNT_ONE) : q.errs;

    // Both limits compared on every block
    assign hit_blocks = (total_nx >= block_count_limit);
    assign hit_errors = (errs_nx >= max_error_limit);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        if (ce)
        begin
            // Synchroniser chains; first stages feed nothing else
            d.tog_s  = {q.tog_s[2:0], blk_tog};
            d.fail_s = {q.fail_s[0], blk_fail};
            d.clk_s  = {q.clk_s[1:0], act_tog};
            d.dat_s  = {q.dat_s[1:0], data_in};

            // Idle counters restart on any transition and saturate;
            // the high reset value must not wrap back into the window
            if (clk_edge)
                d.clk_idle = '0;
            else if (q.clk_idle < IDLE_LIM)
                d.clk_idle = q.clk_idle + 16'h0001;
            if (dat_edge)
                d.dat_idle = '0;
            else if (q.dat_idle < IDLE_LIM)
                d.dat_idle = q.dat_idle + 16'h0001;

            // Sync follows the last block checked; lost with the clock
            if (!clk_act)
                d.sync = 1'b0;
            else if (blk_evt)
                d.sync = ~blk_bad;

            // Measurement sequencer
            unique case (q.meas)
                BLR_IDLE:
                begin
                    if ((mode == BLR_MODE_AUTO) ||
                        ((mode == BLR_MODE_SINGLE) && single_trigger))
                    begin
                        d.meas  = BLR_RUN;
                        d.cause = BLR_TERM_NONE;
                        d.total = `BLR_CNT_RST;
                        d.errs  = `BLR_CNT_RST;
                    end
                end
                BLR_RUN:
                begin
                    if (mode == BLR_MODE_OFF)
                    begin
                        // Abort keeps the partial counts for reading
                        d.meas  = BLR_IDLE;
                        d.cause = BLR_TERM_USER;
                    end
                    else if (blk_evt)
                    begin
                        d.total = total_nx;
                        d.errs  = errs_nx;
                        if (hit_blocks)
                        begin
                            d.meas  = BLR_HOLD;
                            d.cause = BLR_TERM_BLOCKS;
                        end
                        else if (hit_errors)
                        begin
                            d.meas  = BLR_HOLD;
                            d.cause = BLR_TERM_ERRORS;
                        end
                    end
                end
                BLR_HOLD:
                begin
                    // Results frozen until the controller reads them
                    if (mode == BLR_MODE_OFF)
                    begin
                        d.meas = BLR_IDLE;
                    end
                    else if (result_read)
                    begin
                        if (mode == BLR_MODE_AUTO)
                        begin
                            d.meas  = BLR_RUN;
                            d.cause = BLR_TERM_NONE;
                            d.total = `BLR_CNT_RST;
                            d.errs  = `BLR_CNT_RST;
                        end
                        else
                        begin
                            d.meas = BLR_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            q          <= '0;
            q.clk_idle <= 16'hFFFF;
            q.dat_idle <= 16'hFFFF;
            q.meas     <= BLR_IDLE;
            q.cause    <= BLR_TERM_NONE;
        end
        else
        begin
            q <= d;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    // Idle counters reset high so activity starts out absent
    assign total_blocks         = q.total;
    assign failed_blocks        = q.errs;
    assign status.clock_active  = clk_act;
    assign status.data_active   = dat_act;
    assign status.crc_synced    = q.sync;
    assign status.result_valid  = clk_act & dat_act & q.sync;
    assign status.running       = (q.meas == BLR_RUN);
    assign status.done          = (q.meas == BLR_HOLD);
    assign status.cause         = q.cause;
    assign checksum_type        = BLR_CRC16;

endmodule

// ### verilog/blr_map.svh
`ifndef BLR_MAP_SVH
`define BLR_MAP_SVH

// ****************************************************************
// Checksum generator
// ****************************************************************
`define BLR_CRC_W            16
`define BLR_CRC_POLY         16'h1021
`define BLR_CRC_INIT         16'h0000

// ****************************************************************
// Counters
// ****************************************************************
`define BLR_CNT_W            32
`define BLR_CNT_RST          32'h0000_0000
`define BLR_CNT_ONE          32'h0000_0001

// ****************************************************************
// Activity detection timing
// ****************************************************************
`define BLR_CLK_MHZ          50
`define BLR_ACT_TIMEOUT_NS   10000
`define BLR_ACT_TIMEOUT_CYC  ((`BLR_ACT_TIMEOUT_NS * `BLR_CLK_MHZ) / 1000)
`define BLR_IDLE_W           16

// ****************************************************************
// Synchroniser depths
// ****************************************************************
`define BLR_TOG_SYNC         4
`define BLR_PIN_SYNC         3

`endif

// ### verilog/blr_pkg.sv
`include "blr_map.svh"

package blr_pkg;

    // ****************************************************************
    // Modes, states and codes
    // ****************************************************************
    // Measurement mode as seen at the control input
    typedef enum logic [1:0] {
        BLR_MODE_OFF,
        BLR_MODE_AUTO,
        BLR_MODE_SINGLE
    } blr_mode_t;

    // What ended the last measurement
    typedef enum logic [1:0] {
        BLR_TERM_NONE,
        BLR_TERM_BLOCKS,
        BLR_TERM_ERRORS,
        BLR_TERM_USER
    } blr_term_t;

    // Only one checksum kind exists
    typedef enum logic [0:0] {
        BLR_CRC16
    } blr_crc_type_t;

    // Measurement sequencer
    typedef enum logic [1:0] {
        BLR_IDLE,
        BLR_RUN,
        BLR_HOLD
    } blr_meas_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    // Configuration handed to the link side
    typedef struct packed {
        logic data_complement_sense;
        logic enable_polarity_select;
        logic falling_edge_sample;
    } blr_cfg_t;

    // Status bundle driven by the top
    typedef struct packed {
        logic      clock_active;
        logic      data_active;
        logic      crc_synced;
        logic      result_valid;
        logic      running;
        logic      done;
        blr_term_t cause;
    } blr_status_t;

    // ****************************************************************
    // State records
    // ****************************************************************
    typedef struct packed {
        logic [1:0]  inv_s;
        logic [1:0]  pol_s;
        logic [15:0] crc;
        logic [15:0] chk;
        logic        seen_chk;
        logic        prev_info;
        logic        evt_tog;
        logic        fail;
        logic        act_tog;
    } blr_lnk_st_t;

    typedef struct packed {
        logic [3:0]  tog_s;
        logic [1:0]  fail_s;
        logic [2:0]  clk_s;
        logic [2:0]  dat_s;
        logic [15:0] clk_idle;
        logic [15:0] dat_idle;
        logic        sync;
        blr_meas_t   meas;
        blr_term_t   cause;
        logic [31:0] total;
        logic [31:0] errs;
    } blr_top_st_t;

    // ****************************************************************
    // One step of the serial checksum, first bit in at the top
    // ****************************************************************
    function automatic logic [15:0] blr_crc_step(input logic [15:0] crc,
                                                 input logic        din);
        logic fb;
        fb = crc[15] ^ din;
        blr_crc_step = {crc[14:0], 1'b0} ^ (fb ? `BLR_CRC_POLY : `BLR_CRC_INIT);
    endfunction

endpackage

// ### verilog/blr_link.sv
`timescale 1ns/10ps
`include "blr_map.svh"

module blr_link
(
    // Link clock and reset
    input  wire logic          bit_clk,
    input  wire logic          nrst,
    // Link pins, synchronous to the bit clock
    input  wire logic          data_in,
    input  wire logic          enable_in,
    // Configuration from the system domain
    input  wire blr_pkg::blr_cfg_t cfg,
    // Crossing outputs
    output logic               blk_tog,
    output logic               blk_fail,
    output logic               act_tog
);
    import blr_pkg::*;

    blr_lnk_st_t q;
    blr_lnk_st_t d;
    logic        smp_clk;
    logic        bit_v;
    logic        info;

    // ****************************************************************
    // Sampling edge
    // ****************************************************************
    // Slope select flips the clock; change it only while the link is idle
    assign smp_clk = bit_clk ^ cfg.falling_edge_sample;

    // Sense and role of the sampled bit, from synchronised settings
    assign bit_v = data_in ^ q.inv_s[1];
    assign info  = (enable_in == q.pol_s[1]);

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        d = q;
        d.inv_s = {q.inv_s[0], cfg.data_complement_sense};
        d.pol_s = {q.pol_s[0], cfg.enable_polarity_select};
        d.act_tog = ~q.act_tog;
        d.prev_info = info;
        if (info)
        begin
            if (!q.prev_info)
            begin
                // Start of information ends the previous block
                if (q.seen_chk)
                begin
                    d.evt_tog = ~q.evt_tog;
                    d.fail = (q.crc != q.chk);
                end
                d.seen_chk = 1'b0;
                d.crc = blr_crc_step(`BLR_CRC_INIT, bit_v);
            end
            else
            begin
                d.crc = blr_crc_step(q.crc, bit_v);
            end
        end
        else
        begin
            // Checksum bits go to their own register
            d.chk = {q.chk[14:0], bit_v};
            d.seen_chk = 1'b1;
        end
    end

    // Register the state on the chosen edge
    always_ff @(posedge smp_clk or negedge nrst)
    begin
        if (!nrst)
            q <= '0;
        else
            q <= d;
    end

    assign blk_tog  = q.evt_tog;
    assign blk_fail = q.fail;
    assign act_tog  = q.act_tog;

endmodule

// ### tb/blr_top_chk.sv
`timescale 1ns/10ps

module blr_chk
#(
    parameter int unsigned ACT_TIMEOUT_CYC = 500
)
(
    // Clocks and reset
    input wire logic                   clk,
    input wire logic                   nrst,
    input wire logic                   ce,
    input wire logic                   bit_clk,
    // Controls
    input wire blr_pkg::blr_mode_t     mode,
    input wire logic [31:0]            block_count_limit,
    input wire logic [31:0]            max_error_limit,
    input wire logic                   single_trigger,
    input wire logic                   result_read,
    // Results
    input wire logic [31:0]            total_blocks,
    input wire logic [31:0]            failed_blocks,
    input wire blr_pkg::blr_status_t   status,
    input wire blr_pkg::blr_crc_type_t checksum_type
);
    import blr_pkg::*;
    // ********
    // Bit clock idle time, saturating so it never wraps
    // ********
    logic        bclk_q;
    logic [15:0] idle_q;
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            bclk_q <= 1'b0;
            idle_q <= 16'h0000;
        end
        else
        begin
            bclk_q <= bit_clk;
            if (bit_clk != bclk_q)
                idle_q <= 16'h0000;
            else if (idle_q != 16'hFFFF)
                idle_q <= idle_q + 16'h0001;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    type_fixed_a: assert property (checksum_type == BLR_CRC16)
        else $error("checksum type changed");
    blk_stop_a: assert property ($changed(total_blocks) && $past(status.running)
        && total_blocks != 32'h0 && total_blocks >= block_count_limit |-> status.done)
        else $error("block limit did not stop");
    err_stop_a: assert property ($changed(failed_blocks) && $past(status.running)
        && failed_blocks != 32'h0 && failed_blocks >= max_error_limit |-> status.done)
        else $error("error limit did not stop");
    stop_cause_a: assert property ($rose(status.done) |->
        (status.cause == BLR_TERM_BLOCKS) == (total_blocks >= block_count_limit))
        else $error("wrong stop cause");
    hold_a: assert property (status.done && !result_read && mode != BLR_MODE_OFF |=>
        status.done && $stable(total_blocks) && $stable(failed_blocks))
        else $error("finished run not held");
    release_a: assert property (status.done && result_read && ce |=> !status.done)
        else $error("read did not release");
    auto_again_a: assert property (status.done && result_read && ce &&
        mode == BLR_MODE_AUTO |=> status.running && total_blocks == 32'h0)
        else $error("auto did not restart");
    user_stop_a: assert property (status.running && ce && mode == BLR_MODE_OFF |=>
        !status.running && status.cause == BLR_TERM_USER)
        else $error("off did not abort");
    single_go_a: assert property (!status.running && !status.done && ce &&
        mode == BLR_MODE_SINGLE && single_trigger |=> status.running)
        else $error("trigger did not start");
    blk_step_a: assert property ($changed(total_blocks) && total_blocks != 32'h0 |->
        total_blocks == $past(total_blocks) + 32'h1)
        else $error("block count step wrong");
    err_step_a: assert property ($changed(failed_blocks) && failed_blocks != 32'h0 |->
        failed_blocks == $past(failed_blocks) + 32'h1 && $changed(total_blocks))
        else $error("error count step wrong");
    valid_and_a: assert property (status.result_valid ==
        (status.clock_active && status.data_active && status.crc_synced))
        else $error("valid flag wrong");
    clk_idle_a: assert property (idle_q > ACT_TIMEOUT_CYC + 8 |-> !status.clock_active)
        else $error("clock activity stuck");

    // Main outcomes
    cover property ($rose(status.done) && status.cause == BLR_TERM_BLOCKS);
    cover property ($rose(status.done) && status.cause == BLR_TERM_ERRORS);
    cover property ($rose(status.cause == BLR_TERM_USER));
endmodule

bind blr_top blr_chk #(.ACT_TIMEOUT_CYC(ACT_TIMEOUT_CYC)) blr_chk_i
(
    .clk(clk), .nrst(nrst), .ce(ce), .bit_clk(bit_clk), .mode(mode),
    .block_count_limit(block_count_limit), .max_error_limit(max_error_limit),
    .single_trigger(single_trigger), .result_read(result_read),
    .total_blocks(total_blocks), .failed_blocks(failed_blocks),
    .status(status), .checksum_type(checksum_type)
);

// ### tb/blr_far_end.sv
`timescale 1ns/10ps

module blr_far_end
(
    // Settings the source follows
    input wire blr_pkg::blr_cfg_t cfg,
    // Link pins, clock parked low between frames
    output logic                  bit_clk,
    output logic                  data_in,
    output logic                  enable_in
);
    import blr_pkg::*;
    // Quiet lines at start
    initial
    begin
        bit_clk = 1'b0;
        data_in = 1'b0;
        enable_in = 1'b0;
    end
    // ********
    // One bit; data is valid only around the chosen edge
    // ********
    task automatic send_bit(input logic info, input logic b);
        data_in = b ^ cfg.data_complement_sense ^ cfg.falling_edge_sample;
        enable_in = ~(info ^ cfg.enable_polarity_select);
        #3.75 bit_clk = 1'b1;
        #3.75 data_in = ~data_in;
        #3.75 bit_clk = 1'b0;
        #3.75;
    endtask
    // Released lines show the inverse of their last level
    task automatic release_lines();
        data_in = ~data_in;
        enable_in = ~enable_in;
    endtask
    // Sixteen information bits, then their checksum; one bit spoiled if bad
    task automatic send_block(input logic [15:0] info, input logic bad);
        logic [15:0] crc;
        crc = 16'h0000;
        for (int i = 15; i >= 0; i--)
        begin
            send_bit(1'b1, info[i]);
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ info[i]) ? 16'h1021 : 16'h0000);
        end
        crc[0] = crc[0] ^ bad;
        for (int i = 15; i >= 0; i--)
            send_bit(1'b0, crc[i]);
        release_lines();
    endtask
    // A zero information bit closes the last block and leaves a zero checksum
    task automatic flush();
        send_bit(1'b1, 1'b0);
        release_lines();
    endtask
endmodule

// ### tb/blr_top_tb.sv
`timescale 1ns/10ps

module blr_top_tb;
    import blr_pkg::*;
    localparam int unsigned ACT = 50;
    // ********
    // Pins and counters
    // ********
    logic          clk = 1'b0;
    logic          nrst = 1'b0;
    logic          ce = 1'b1;
    logic          single_trigger = 1'b0;
    logic          result_read = 1'b0;
    logic          bit_clk;
    logic          data_in;
    logic          enable_in;
    blr_cfg_t      cfg = 3'h0;
    blr_mode_t     mode = BLR_MODE_OFF;
    logic [31:0]   block_count_limit = 32'h1;
    logic [31:0]   max_error_limit = 32'h1;
    logic [31:0]   total_blocks;
    logic [31:0]   failed_blocks;
    blr_status_t   status;
    blr_crc_type_t checksum_type;
    int            err_count = 0;
    int            comparisons = 0;
    int            cycles = 0;

    // System clock, 50 MHz
    always #10 clk = ~clk;

    blr_top #(.ACT_TIMEOUT_CYC(ACT)) blr_top_i
    (
        .clk(clk), .nrst(nrst), .ce(ce), .bit_clk(bit_clk), .data_in(data_in),
        .enable_in(enable_in), .cfg(cfg), .mode(mode),
        .block_count_limit(block_count_limit), .max_error_limit(max_error_limit),
        .single_trigger(single_trigger), .result_read(result_read),
        .total_blocks(total_blocks), .failed_blocks(failed_blocks),
        .status(status), .checksum_type(checksum_type)
    );
    blr_far_end blr_far_end_i
    (
        .cfg(cfg), .bit_clk(bit_clk), .data_in(data_in), .enable_in(enable_in)
    );

    // Hang guard, far above the roughly one thousand cycles needed
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            err_count++;
            wrap_up();
        end
    end
    // ********
    // Shared helpers
    // ********
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("comparisons=%0d mismatches=%0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic setup(input blr_mode_t m, input logic [31:0] bl, input logic [31:0] el);
        @(posedge clk);
        mode <= m;
        block_count_limit <= bl;
        max_error_limit <= el;
    endtask
    // One-cycle trigger (trig=1) or result read (trig=0)
    task automatic strobe(input logic trig);
        @(posedge clk);
        single_trigger <= trig;
        result_read <= ~trig;
        @(posedge clk);
        single_trigger <= 1'b0;
        result_read <= 1'b0;
    endtask
    // Blocks, then the closing bit; counts land a few cycles later
    task automatic traffic(input int n, input logic [7:0] bad);
        for (int i = 0; i < n; i++)
            blr_far_end_i.send_block(16'hA5C3 ^ (16'(i) * 16'h1357), bad[i]);
        blr_far_end_i.flush();
        settle(8);
    endtask
    // ********
    // Scenarios
    // ********
    task automatic t_blocks();
        check({24'h0, status}, 32'h0);
        check({31'h0, checksum_type}, 32'h0);
        setup(BLR_MODE_SINGLE, 32'h3, 32'h9);
        strobe(1'b1);
        settle(1);
        check({31'h0, status.running}, 32'h1);
        traffic(4, 8'h00);
        check(total_blocks, 32'h3);
        check(failed_blocks, 32'h0);
        check({24'h0, status}, 32'hF5);
        strobe(1'b0);
        settle(1);
        check({24'h0, status} & 32'hC, 32'h0);
        settle(ACT + 20);
        check({24'h0, status} & 32'hD0, 32'h0);
        $display("test blocks done");
    endtask
    task automatic t_errors();
        setup(BLR_MODE_SINGLE, 32'hA, 32'h2);
        strobe(1'b1);
        traffic(3, 8'h06);
        check(total_blocks, 32'h3);
        check(failed_blocks, 32'h2);
        check({24'h0, status}, 32'hC6);
        strobe(1'b0);
        $display("test errors done");
    endtask
    task automatic t_auto();
        setup(BLR_MODE_AUTO, 32'h2, 32'h5);
        traffic(2, 8'h00);
        check({24'h0, status}, 32'hF5);
        strobe(1'b0);
        settle(1);
        check({31'h0, status.running}, 32'h1);
        check(total_blocks, 32'h0);
        setup(BLR_MODE_OFF, 32'h2, 32'h5);
        ce <= 1'b0;
        settle(2);
        check({31'h0, status.running}, 32'h1);
        @(posedge clk);
        ce <= 1'b1;
        settle(1);
        check({29'h0, status.running, status.cause}, 32'h3);
        $display("test auto done");
    endtask
    task automatic t_cfg();
        for (int c = 0; c < 8; c++)
        begin
            @(posedge clk);
            cfg <= blr_cfg_t'(3'(c));
            setup(BLR_MODE_SINGLE, 32'h2, 32'h5);
            traffic(1, 8'h00);
            strobe(1'b1);
            traffic(2, 8'h00);
            check(total_blocks, 32'h2);
            check(failed_blocks, 32'h0);
            strobe(1'b0);
        end
        $display("test settings done");
    endtask
    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        settle(1);
        t_blocks();
        t_errors();
        t_auto();
        t_cfg();
        wrap_up();
    end
endmodule
